// File: src/rtw_pkg.sv
// Constants, types and register map of the calendar, trim and weekly alarm block
package rtw_pkg;

  // ----------------------------------------
  // Register offsets
  // ----------------------------------------
  localparam logic [3:0] ADDR_WDAY = 4'h3;
  localparam logic [3:0] ADDR_DAY = 4'h4;
  localparam logic [3:0] ADDR_MONTH = 4'h5;
  localparam logic [3:0] ADDR_YEAR = 4'h6;
  localparam logic [3:0] ADDR_TRIM = 4'h7;
  localparam logic [3:0] ADDR_WMIN = 4'h8;
  localparam logic [3:0] ADDR_WHOUR = 4'h9;
  localparam logic [3:0] ADDR_WMASK = 4'hA;

  // ----------------------------------------
  // Field positions
  // ----------------------------------------
  localparam int CENTURY_BIT = 7;
  localparam int TRIM_INTERVAL_BIT = 7;
  localparam int TRIM_SIGN_BIT = 6;

  // ----------------------------------------
  // BCD calendar limits
  // ----------------------------------------
  localparam logic [5:0] DAY_FIRST = 6'h01;
  localparam logic [5:0] DAY_28 = 6'h28;
  localparam logic [5:0] DAY_29 = 6'h29;
  localparam logic [5:0] DAY_30 = 6'h30;
  localparam logic [5:0] DAY_31 = 6'h31;
  localparam logic [4:0] MON_FIRST = 5'h01;
  localparam logic [4:0] MON_FEB = 5'h02;
  localparam logic [4:0] MON_APR = 5'h04;
  localparam logic [4:0] MON_JUN = 5'h06;
  localparam logic [4:0] MON_SEP = 5'h09;
  localparam logic [4:0] MON_NOV = 5'h11;
  localparam logic [4:0] MON_LAST = 5'h12;
  localparam logic [7:0] YEAR_FIRST = 8'h00;
  localparam logic [7:0] YEAR_LAST = 8'h99;
  localparam logic [2:0] WDAY_FIRST = 3'h0;
  localparam logic [2:0] WDAY_LAST = 3'h6;

  // ----------------------------------------
  // Second divider and trim points
  // ----------------------------------------
  localparam logic [15:0] SEC_NOMINAL = 16'h8000;
  localparam logic [6:0] SEC_00 = 7'h00;
  localparam logic [6:0] SEC_20 = 7'h20;
  localparam logic [6:0] SEC_40 = 7'h40;

  // ----------------------------------------
  // Alarm flag delay, in ns and in cycles
  // ----------------------------------------
  localparam int CLK_PERIOD_NS = 10;
  localparam int ALARM_DELAY_NS = 31000;
  localparam int ALARM_DELAY_CYC = ALARM_DELAY_NS / CLK_PERIOD_NS;

  // ----------------------------------------
  // Types
  // ----------------------------------------
  typedef enum logic [0:0] {
    AL_IDLE = 1'b0,
    AL_WAIT = 1'b1
  } rtw_alarm_e;

  typedef struct packed {
    logic wr;
    logic [3:0] addr;
    logic [7:0] wdata;
  } rtw_bus_req_s;

  typedef struct packed {
    logic [6:0] sec;
    logic [6:0] min;
    logic [5:0] hour;
  } rtw_time_s;

  typedef struct packed {
    logic [5:0] day;
    logic [4:0] month;
    logic century;
    logic [7:0] year;
    logic [7:0] trim;
    logic [6:0] wmin;
    logic [5:0] whour;
    logic [6:0] wmask;
    logic [2:0] wday;
    logic [15:0] div;
    logic skip;
    logic tick;
    logic match_q;
    rtw_alarm_e al;
    logic [11:0] dly;
    logic flag;
    logic [7:0] rdata;
  } rtw_state_s;

endpackage

// File: src/rtw_calendar_trim.sv
// Calendar counters, second trim divider and weekly alarm of the clock
//
// What this block does
// - Day counts BCD 1-31 in long months, 1-30 in short months.
// - February runs to 29 in leap years, otherwise to 28.
// - Day wrap from last day to 1 increments the month.
// - Month counts BCD 1-12; wrap from 12 to 1 increments year.
// - Year counts BCD 00-99; every multiple of four is leap, 00 included.
// - Century bit toggles when the year wraps from 99 to 00.
// - Day register at 4h holds six BCD bits; top two read zero.
// - Register 5h holds century in D7, month in D4-D0; D6-D5 zero.
// - Year register at 6h is a full read-write eight-bit BCD year.
// - After power-up the trim register reads zero; calendar may be anything.
// - Interval bit 0 applies correction at seconds 00, 20 and 40.
// - Interval bit 1 applies correction only at second 00.
// - A correction point coinciding with a trim write is skipped.
// - Sign 0 lengthens that second by twice magnitude minus one.
// - Sign 1 shortens that second by the same doubled amount.
// - Magnitude zero or one gives no correction at all.
// - Only the second divider is trimmed, never the oscillator tick.
// - Alarm minute at 8h, hour at 9h, day mask at Ah; top bits zero.
// - Alarm hour D5 is PM flag in 12-hour mode, hour tens in 24-hour.
// - In 12-hour mode midnight encodes 12 and noon encodes 32.
// - Mask bits map weekday codes 0-6; all zero never fires.
// - Power-on detection clears every trim bit.
// - Enabled alarm flag sets about 31 us after the match.
// - Weekday counter advances with the day, wrapping 6 to 0.
`timescale 1ns/1ps

module rtw_calendar_trim
  import rtw_pkg::*;
(
  input wire logic core_clk, // 100 MHz clock
  input wire logic resetn, // Async reset, low active
  input wire rtw_bus_req_s bus_req, // Register write and read address
  output logic [7:0] rdata, // Read data, one cycle after addr
  input wire logic osc_tick, // One pulse per oscillator cycle
  input wire rtw_time_s time_now, // Current BCD time
  input wire logic day_carry, // Pulse when hours roll over
  input wire logic power_up_flag, // Power-on detected, level
  input wire logic weekly_alarm_enable, // Alarm enable, level
  input wire logic alarm_flag_clear, // Software clears the flag
  output logic second_tick, // Pulse at each trimmed second
  output logic [2:0] weekday, // Day-of-week code
  output logic weekly_alarm_match_flag // Alarm flag
);

  localparam int DLY_LAST = ALARM_DELAY_CYC - 1;

  // ----------------------------------------
  // Reset release
  // ----------------------------------------
  logic [1:0] rst_sync;
  logic rst_n;

  // Two-stage release keeps state out of metastability
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      rst_sync <= 2'b00;
    end else begin
      rst_sync <= {rst_sync[0], 1'b1};
    end
  end

  assign rst_n = rst_sync[1];

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  // BCD increment of a two-digit value
  function automatic logic [7:0] bcd_inc(input logic [7:0] v);
    if (v[3:0] == 4'h9) begin
      bcd_inc = {4'(v[7:4] + 4'h1), 4'h0};
    end else begin
      bcd_inc = {v[7:4], 4'(v[3:0] + 4'h1)};
    end
  endfunction

  // Odd tens need units 2 or 6, even tens units 0, 4 or 8
  function automatic logic is_leap(input logic [7:0] y);
    if (y[4]) begin
      is_leap = (y[3:0] == 4'h2) || (y[3:0] == 4'h6);
    end else begin
      is_leap = (y[1:0] == 2'b00);
    end
  endfunction

  function automatic logic [5:0] last_day(input logic [4:0] mo, input logic leap);
    case (mo)
      MON_FEB: last_day = leap ? DAY_29 : DAY_28;
      MON_APR, MON_JUN, MON_SEP, MON_NOV: last_day = DAY_30;
      default: last_day = DAY_31;
    endcase
  endfunction

  // ----------------------------------------
  // State
  // ----------------------------------------
  rtw_state_s st;
  rtw_state_s next_st;
  logic wr_trim;
  logic at_point;
  logic [5:0] mag;
  logic [15:0] adj;
  logic [15:0] len_m1;
  logic [5:0] day_last;
  logic mask_hit;
  logic match_now;

  // Correction point and trimmed length of the current second
  always_comb begin
    wr_trim = bus_req.wr && (bus_req.addr == ADDR_TRIM);
    mag = st.trim[5:0];
    adj = {9'h000, 6'(mag - 6'h01), 1'b0};
    if (st.trim[TRIM_INTERVAL_BIT]) begin
      at_point = (time_now.sec == SEC_00);
    end else begin
      at_point = (time_now.sec == SEC_00) || (time_now.sec == SEC_20)
        || (time_now.sec == SEC_40);
    end
    len_m1 = 16'(SEC_NOMINAL - 16'h0001);
    // Magnitudes 0 and 1 leave the second nominal
    if (at_point && !st.skip && (mag > 6'h01)) begin
      if (st.trim[TRIM_SIGN_BIT]) begin
        len_m1 = 16'(len_m1 - adj);
      end else begin
        len_m1 = 16'(len_m1 + adj);
      end
    end
  end

  // Month length and alarm match
  always_comb begin
    day_last = last_day(st.month, is_leap(st.year));
    // Code 7 is unused and must never select a mask bit
    mask_hit = (st.wday <= WDAY_LAST) && st.wmask[st.wday];
    match_now = mask_hit && (time_now.min == st.wmin)
      && (time_now.hour == st.whour);
  end

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  always_comb begin
    next_st = st;
    next_st.tick = 1'b0;

    // Second divider; the oscillator tick itself is never altered
    if (osc_tick) begin
      if (st.div >= len_m1) begin
        next_st.div = 16'h0000;
        next_st.tick = 1'b1;
      end else begin
        next_st.div = 16'(st.div + 16'h0001);
      end
    end

    // Skip lasts to the end of the second, so a late write still cancels
    if (next_st.tick) begin
      next_st.skip = 1'b0;
    end
    if (wr_trim && at_point) begin
      next_st.skip = 1'b1;
    end

    // Calendar carry chain
    if (day_carry) begin
      if (st.wday >= WDAY_LAST) begin
        next_st.wday = WDAY_FIRST;
      end else begin
        next_st.wday = 3'(st.wday + 3'h1);
      end
      if (st.day == day_last) begin
        next_st.day = DAY_FIRST;
        if (st.month == MON_LAST) begin
          next_st.month = MON_FIRST;
          if (st.year == YEAR_LAST) begin
            next_st.year = YEAR_FIRST;
            next_st.century = !st.century;
          end else begin
            next_st.year = bcd_inc(st.year);
          end
        end else begin
          next_st.month = 5'(bcd_inc({3'b000, st.month}));
        end
      end else begin
        next_st.day = 6'(bcd_inc({2'b00, st.day}));
      end
    end

    // Register writes win over a carry in the same cycle
    if (bus_req.wr) begin
      case (bus_req.addr)
        ADDR_WDAY: next_st.wday = bus_req.wdata[2:0];
        ADDR_DAY: next_st.day = bus_req.wdata[5:0];
        ADDR_MONTH: begin
          next_st.month = bus_req.wdata[4:0];
          next_st.century = bus_req.wdata[CENTURY_BIT];
        end
        ADDR_YEAR: next_st.year = bus_req.wdata;
        ADDR_TRIM: next_st.trim = bus_req.wdata;
        ADDR_WMIN: next_st.wmin = bus_req.wdata[6:0];
        ADDR_WHOUR: next_st.whour = bus_req.wdata[5:0];
        ADDR_WMASK: next_st.wmask = bus_req.wdata[6:0];
        default: ;
      endcase
    end

    // Power-on detection overrides any trim write
    if (power_up_flag) begin
      next_st.trim = 8'h00;
    end

    // Alarm: a new match starts the flag delay
    next_st.match_q = match_now;
    case (st.al)
      AL_IDLE: begin
        if (match_now && !st.match_q && weekly_alarm_enable) begin
          next_st.al = AL_WAIT;
          next_st.dly = 12'h000;
        end
      end
      AL_WAIT: begin
        if (st.dly == 12'(DLY_LAST)) begin
          next_st.al = AL_IDLE;
          next_st.flag = 1'b1;
        end else begin
          next_st.dly = 12'(st.dly + 12'h001);
        end
      end
      default: next_st.al = AL_IDLE;
    endcase

    // A clear loses to a set arriving in the same cycle
    if (alarm_flag_clear && !(st.al == AL_WAIT && st.dly == 12'(DLY_LAST))) begin
      next_st.flag = 1'b0;
    end
    // Disabled alarm reads zero and drops any pending set
    if (!weekly_alarm_enable) begin
      next_st.flag = 1'b0;
      next_st.al = AL_IDLE;
    end

    // Read data, unused bits and offsets read zero
    case (bus_req.addr)
      ADDR_WDAY: next_st.rdata = {5'h00, st.wday};
      ADDR_DAY: next_st.rdata = {2'b00, st.day};
      ADDR_MONTH: next_st.rdata = {st.century, 2'b00, st.month};
      ADDR_YEAR: next_st.rdata = st.year;
      ADDR_TRIM: next_st.rdata = st.trim;
      ADDR_WMIN: next_st.rdata = {1'b0, st.wmin};
      ADDR_WHOUR: next_st.rdata = {2'b00, st.whour};
      ADDR_WMASK: next_st.rdata = {1'b0, st.wmask};
      default: next_st.rdata = 8'h00;
    endcase
  end

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  // Reset clears everything; calendar values are arbitrary anyway
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign rdata = st.rdata;
  assign second_tick = st.tick;
  assign weekday = st.wday;
  assign weekly_alarm_match_flag = st.flag;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!rst_n);

  a_trim_power_clear: assert property (
    power_up_flag |=> (st.trim == 8'h00))
    else $error("trim not cleared by power-up");

  a_day_wrap_month: assert property (
    (day_carry && !bus_req.wr && st.day == day_last && st.month != MON_LAST)
    |=> (st.day == DAY_FIRST) && (st.month != $past(st.month)))
    else $error("day wrap did not advance month");

  a_month_wrap_year: assert property (
    (day_carry && !bus_req.wr && st.day == day_last && st.month == MON_LAST
     && st.year != YEAR_LAST)
    |=> (st.month == MON_FIRST) && (st.year == bcd_inc($past(st.year))))
    else $error("month wrap did not advance year");

  a_century_flip: assert property (
    (day_carry && !bus_req.wr && st.day == day_last && st.month == MON_LAST
     && st.year == YEAR_LAST)
    |=> (st.year == YEAR_FIRST) && (st.century != $past(st.century)))
    else $error("century did not toggle");

  // Leap test worked out in binary, so a broken BCD shortcut still shows up
  a_feb_length: assert property (
    (st.month == MON_FEB) |-> (day_last == (((((st.year[7:4] * 10) + st.year[3:0]) % 4) == 0) ? DAY_29 : DAY_28)))
    else $error("wrong february length");

  a_weekday_step: assert property (
    (day_carry && !bus_req.wr && st.wday < WDAY_LAST) |=> (st.wday == 3'($past(st.wday) + 3'h1)))
    else $error("weekday did not advance");

  a_day_read_zero: assert property (
    (bus_req.addr == ADDR_DAY) |=> (rdata[7:6] == 2'b00))
    else $error("day register top bits not zero");

  a_month_read_zero: assert property (
    (bus_req.addr == ADDR_MONTH) |=> (rdata[6:5] == 2'b00))
    else $error("month register spare bits not zero");

  a_alarm_read_zero: assert property (
    (bus_req.addr == ADDR_WMIN || bus_req.addr == ADDR_WMASK) |=> !rdata[7])
    else $error("alarm register top bit not zero");

  a_weekday_wrap: assert property (
    (day_carry && !bus_req.wr && st.wday == WDAY_LAST) |=> (st.wday == WDAY_FIRST))
    else $error("weekday did not wrap");

  a_trim_small_mag: assert property (
    (mag <= 6'h01) |-> (len_m1 == 16'(SEC_NOMINAL - 16'h0001)))
    else $error("small magnitude changed second");

  a_trim_lengthen: assert property (
    (at_point && !st.skip && mag > 6'h01 && !st.trim[TRIM_SIGN_BIT])
    |-> (len_m1 == 16'(SEC_NOMINAL - 16'h0001 + {9'h000, 6'(mag - 6'h01), 1'b0})))
    else $error("lengthened second has wrong count");

  a_trim_shorten: assert property (
    (at_point && !st.skip && mag > 6'h01 && st.trim[TRIM_SIGN_BIT])
    |-> (len_m1 == 16'(SEC_NOMINAL - 16'h0001 - {9'h000, 6'(mag - 6'h01), 1'b0})))
    else $error("shortened second has wrong count");

  a_trim_points: assert property (
    (!st.trim[TRIM_INTERVAL_BIT] && mag > 6'h01 && !st.skip && time_now.sec == SEC_20)
    |-> (len_m1 != 16'(SEC_NOMINAL - 16'h0001)))
    else $error("no correction at second 20");

  a_trim_interval: assert property (
    (st.trim[TRIM_INTERVAL_BIT] && time_now.sec != SEC_00)
    |-> (len_m1 == 16'(SEC_NOMINAL - 16'h0001)))
    else $error("correction outside second 00");

  a_trim_skip: assert property (
    (wr_trim && at_point && !osc_tick) |=> (len_m1 == 16'(SEC_NOMINAL - 16'h0001))
    || !at_point)
    else $error("correction applied after trim write");

  a_sec_end: assert property (
    (osc_tick && st.div == len_m1) |=> second_tick && (st.div == 16'h0000))
    else $error("second did not end at trimmed length");

  a_alarm_delay: assert property (
    $rose(st.flag) |-> $past(st.al == AL_WAIT) && ($past(st.dly) == 12'(DLY_LAST)))
    else $error("alarm flag set without full delay");

  a_alarm_mask: assert property (
    (st.al == AL_IDLE ##1 st.al == AL_WAIT) |-> $past(mask_hit))
    else $error("alarm started on unmasked day");

  a_alarm_disabled: assert property (
    !weekly_alarm_enable |=> !weekly_alarm_match_flag)
    else $error("flag set while alarm disabled");

endmodule // rtw_calendar_trim

// File: testbench/rtw_host_model.sv
// Host model: register writes and reads on the block's bus
`timescale 1ns/1ps

module rtw_host_model
  import rtw_pkg::*;
(
  input wire logic core_clk, // Block clock
  output rtw_bus_req_s bus_req, // Request to the block
  output logic rd_valid // High while read data is settled
);
  initial begin
    bus_req = '0;
    rd_valid = 1'b0;
  end

  // One write strobe cycle, request held until the taking edge
  task automatic write_reg(input logic [3:0] a, input logic [7:0] d);
    @(posedge core_clk);
    #1;
    bus_req = '{wr: 1'b1, addr: a, wdata: d};
    @(posedge core_clk);
    #1;
    bus_req.wr = 1'b0;
  endtask

  // Address held over two edges so rdata stays put while rd_valid is up
  task automatic read_reg(input logic [3:0] a);
    @(posedge core_clk);
    #1;
    bus_req.addr = a;
    @(posedge core_clk);
    #1;
    rd_valid = 1'b1;
    @(posedge core_clk);
    #1;
    rd_valid = 1'b0;
  endtask
endmodule // rtw_host_model

// File: testbench/rtw_calendar_trim_bench.sv
// Self-checking bench of the calendar, trim and weekly alarm block
`timescale 1ns/1ps

module rtw_calendar_trim_bench import rtw_pkg::*;;
  logic core_clk;
  logic resetn;
  logic osc_tick;
  rtw_time_s time_now;
  logic day_carry;
  logic power_up_flag;
  logic weekly_alarm_enable;
  logic alarm_flag_clear;
  rtw_bus_req_s bus_req;
  logic rd_valid;
  logic [7:0] rdata;
  logic second_tick;
  logic [2:0] weekday;
  logic weekly_alarm_match_flag;
  logic flag_prev;
  int num_errors = 0;
  int total_checks = 0;
  int cyc = 0;
  int tick_cnt = 0;
  logic [31:0] rng = 32'hA4AD6251;
  logic [7:0] rd_q[$];
  int cnt_q[$];
  logic [3:0] addrs [7] = '{ADDR_DAY, ADDR_MONTH, ADDR_YEAR, ADDR_WMIN, ADDR_WHOUR, ADDR_WMASK, 4'hB};
  logic [7:0] masks [7] = '{8'h3F, 8'h9F, 8'hFF, 8'h7F, 8'h3F, 8'h7F, 8'h00};
  // Day, month, year before a carry, then after it
  logic [47:0] cal [9] = '{48'h310123_010223, 48'h300423_010523, 48'h300123_310123, 48'h280223_010323,
    48'h280224_290224, 48'h290200_010300, 48'h311219_010120, 48'h311299_018100, 48'h319299_010100};

  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end

  rtw_calendar_trim dut (.core_clk(core_clk), .resetn(resetn), .bus_req(bus_req), .rdata(rdata),
    .osc_tick(osc_tick), .time_now(time_now), .day_carry(day_carry), .power_up_flag(power_up_flag),
    .weekly_alarm_enable(weekly_alarm_enable), .alarm_flag_clear(alarm_flag_clear),
    .second_tick(second_tick), .weekday(weekday), .weekly_alarm_match_flag(weekly_alarm_match_flag));

  rtw_host_model host (.core_clk(core_clk), .bus_req(bus_req), .rd_valid(rd_valid));

  // ----------------------------------------
  // Compare tasks and verdict
  // ----------------------------------------
  task automatic cmp_rd(input logic [7:0] exp, input logic [7:0] got);
    total_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("CHECK FAILED t=%0t exp=%h got=%h", $time, exp, got);
    end
  endtask

  task automatic cmp_count(input int exp, input int got);
    total_checks++;
    if (got != exp) begin
      num_errors++;
      $display("CHECK FAILED t=%0t exp=%h got=%h", $time, exp, got);
    end
  endtask

  task automatic finish_test();
    $display("checks %0d errors %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction

  task automatic expect_rd(input logic [3:0] a, input logic [7:0] e);
    rd_q.push_back(e);
    host.read_reg(a);
  endtask

  task automatic pulse_carry();
    @(posedge core_clk);
    #1 day_carry = 1'b1;
    @(posedge core_clk);
    #1 day_carry = 1'b0;
  endtask

  task automatic wait_second();
    for (int n = 0; n < 40000; n++) begin
      @(posedge core_clk);
      #1;
      if (second_tick === 1'b1) break;
    end
  endtask

  // ----------------------------------------
  // Monitors: edge count, osc ticks per second, results off the queues
  // ----------------------------------------
  always @(posedge core_clk) begin
    cyc = cyc + 1;
    if (osc_tick) tick_cnt = tick_cnt + 1;
  end

  always @(negedge core_clk) begin
    if (rd_valid === 1'b1 && rd_q.size() > 0) cmp_rd(rd_q.pop_front(), rdata);
    if (second_tick === 1'b1) begin
      cmp_count(cnt_q.size() > 0 ? cnt_q.pop_front() : -1, tick_cnt);
      tick_cnt = 0;
    end
    // A rise nobody announced is a mismatch, which covers the empty day mask
    if (weekly_alarm_match_flag === 1'b1 && flag_prev !== 1'b1)
      cmp_count(cnt_q.size() > 0 ? cnt_q.pop_front() : -1, cyc);
    flag_prev = weekly_alarm_match_flag;
  end

  initial begin
    #1000000;
    num_errors++;
    finish_test();
  end

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    resetn = 1'b0;
    osc_tick = 1'b0;
    time_now = '{sec: 7'h21, min: 7'h00, hour: 6'h00};
    day_carry = 1'b0;
    power_up_flag = 1'b0;
    weekly_alarm_enable = 1'b0;
    alarm_flag_clear = 1'b0;
    repeat (5) @(posedge core_clk);
    #1 resetn = 1'b1;
    repeat (3) @(posedge core_clk);
    expect_rd(ADDR_TRIM, 8'h00);
    host.write_reg(ADDR_TRIM, 8'h55);
    @(posedge core_clk);
    #1 power_up_flag = 1'b1;
    @(posedge core_clk);
    #1 power_up_flag = 1'b0;
    expect_rd(ADDR_TRIM, 8'h00);
    // Random data shows reserved bits reading zero in every register but the weekday and trim ones
    for (int i = 0; i < 7; i++) begin
      rng = xs(rng);
      host.write_reg(addrs[i], rng[7:0]);
      expect_rd(addrs[i], rng[7:0] & masks[i]);
    end
    for (int i = 0; i < 9; i++) begin
      host.write_reg(ADDR_DAY, cal[i][47:40]);
      host.write_reg(ADDR_MONTH, cal[i][39:32]);
      host.write_reg(ADDR_YEAR, cal[i][31:24]);
      pulse_carry();
      expect_rd(ADDR_DAY, cal[i][23:16]);
      expect_rd(ADDR_MONTH, cal[i][15:8]);
      expect_rd(ADDR_YEAR, cal[i][7:0]);
    end
    host.write_reg(ADDR_WDAY, 8'h06);
    cmp_rd(8'h06, {5'h00, weekday});
    pulse_carry();
    cmp_rd(8'h00, {5'h00, weekday});
    expect_rd(ADDR_WDAY, 8'h00);
    // Trim written away from a correction point, then the point is reached
    host.write_reg(ADDR_TRIM, 8'h07);
    cnt_q.push_back(32780);
    time_now.sec = 7'h20;
    osc_tick = 1'b1;
    wait_second();
    time_now.sec = 7'h41;
    host.write_reg(ADDR_TRIM, 8'hC3);
    time_now.sec = 7'h00;
    cnt_q.push_back(32764);
    wait_second();
    osc_tick = 1'b0;
    // Rewrite at second 00 sets the skip; osc_tick is stopped, so no second is counted to check it
    host.write_reg(ADDR_TRIM, 8'hC3);
    host.write_reg(ADDR_WMIN, 8'h30);
    host.write_reg(ADDR_WHOUR, 8'h32);
    host.write_reg(ADDR_WMASK, 8'h01);
    weekly_alarm_enable = 1'b1;
    @(posedge core_clk);
    #1 time_now.min = 7'h30;
    time_now.hour = 6'h32;
    cnt_q.push_back(cyc + 1 + ALARM_DELAY_CYC);
    repeat (3200) @(posedge core_clk);
    #1 alarm_flag_clear = 1'b1;
    @(posedge core_clk);
    #1 alarm_flag_clear = 1'b0;
    @(negedge core_clk);
    cmp_rd(8'h00, {7'h00, weekly_alarm_match_flag});
    host.write_reg(ADDR_WMASK, 8'h00);
    time_now.min = 7'h31;
    @(posedge core_clk);
    #1 time_now.min = 7'h30;
    repeat (3200) @(posedge core_clk);
    finish_test();
  end
endmodule // rtw_calendar_trim_bench
